// ===== rtl/iwc_consts.svh
// Register offsets, field positions, reset values and counts of the bus wait control block.
`ifndef IWC_CONSTS_SVH
`define IWC_CONSTS_SVH

`define IWC_OFF_CTRL 8'h00
`define IWC_OFF_STATUS 8'h04
`define IWC_OFF_IRQ_STAT 8'h08
`define IWC_OFF_IRQ_MASK 8'h0C

`define IWC_CTRL_ENABLE 7
`define IWC_CTRL_WREL 6
`define IWC_CTRL_SPIE 4
`define IWC_CTRL_WTIM 3
`define IWC_CTRL_ACKE 2
`define IWC_CTRL_RESET 8'h00

`define IWC_IRQ_WAIT 0
`define IWC_IRQ_STOP 1
`define IWC_IRQ_RESET 2'h0

`define IWC_CNT_START 4'hF
`define IWC_CNT_8TH 4'h7
`define IWC_CNT_9TH 4'h8

`endif

// ===== rtl/iwc_pkg.sv
// Types shared by the bus wait control block.
package iwc_pkg;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } iwc_apb_req_t;

    typedef struct packed {
        logic master_mode;
        logic transmitting;
        logic base_addr_match;
        logic extension_code_flag;
    } iwc_role_t;

    typedef struct packed {
        logic bus_unit_enable;
        logic wait_release;
        logic stop_irq_enable;
        logic wait_timing_select;
        logic ack_enable;
    } iwc_ctrl_t;

    typedef enum logic [1:0] {
        IWC_WAIT_NONE = 2'b00,
        IWC_WAIT_AT_8 = 2'b01,
        IWC_WAIT_AT_9 = 2'b10
    } iwc_wait_pt_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        iwc_ctrl_t ctrl;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [3:0] bit_cnt;
        logic in_frame;
        logic addr_phase;
        logic waiting;
        logic sda_drv;
        logic [31:0] prdata;
        logic pslverr;
    } iwc_state_t;

endpackage

// ===== rtl/iwc_ctrl.sv
// Wait, interrupt timing, stop interrupt and acknowledge control with APB.
//
// Overview of operation
// - Writing one to wait release ends the wait; the bit then clears itself.
// - Stop interrupt enable set: a detected stop raises the interrupt.
// - Wait timing zero: interrupt and clock-low wait at eighth falling edge.
// - Wait timing one: interrupt and clock-low wait at ninth falling edge.
// - Wait timing is ignored during the address byte.
// - Master in address byte waits at the ninth falling edge.
// - Slave matching base address acknowledges, then waits at ninth edge.
// - Slave receiving an extension code waits at the eighth falling edge.
// - Acknowledge enable set: data line held low for the ninth clock while receiving.
// - Acknowledge enable counts in address byte only with extension code.
// - With the unit disabled the control bits have no effect.
// - Reset clears the whole control register to zero.
// - Clearing unit enable stops operation and presets the status.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "iwc_consts.svh"

module iwc_ctrl
    import iwc_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire iwc_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus pins, open drain.
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Role from the rest of the controller.
    input wire iwc_role_t role,
    // Status and interrupt.
    output logic wait_active,
    output logic transfer_interrupt
);

    localparam iwc_state_t RESET_STATE = '{
        scl_s: 3'h7,
        sda_s: 3'h7,
        scl_f: 1'b1,
        sda_f: 1'b1,
        ctrl: '0,
        irq_stat: `IWC_IRQ_RESET,
        irq_mask: `IWC_IRQ_RESET,
        bit_cnt: 4'h0,
        in_frame: 1'b0,
        addr_phase: 1'b0,
        waiting: 1'b0,
        sda_drv: 1'b0,
        prdata: 32'h0000_0000,
        pslverr: 1'b0
    };

    iwc_state_t r;
    iwc_state_t n;

    // The bit counter assumes the ninth count follows the eighth and that
    // the start marker wraps to zero on the clock fall that ends a start.
    if (`IWC_CNT_9TH != `IWC_CNT_8TH + 4'h1) begin : g_count_order
        $error("ninth bit count must follow the eighth");
    end
    if (4'(`IWC_CNT_START + 4'h1) != 4'h0) begin : g_start_wrap
        $error("start marker must wrap to a zero count");
    end
    // Each register takes one aligned word of the bus.
    if (((`IWC_OFF_CTRL | `IWC_OFF_STATUS | `IWC_OFF_IRQ_STAT |
        `IWC_OFF_IRQ_MASK) & 8'h03) != 8'h00) begin : g_word_align
        $error("register offsets must be word aligned");
    end
    // Control fields live in the low byte of the word.
    if (`IWC_CTRL_ENABLE > 7 || `IWC_CTRL_WREL > 7 ||
        `IWC_CTRL_SPIE > 7 || `IWC_CTRL_WTIM > 7 ||
        `IWC_CTRL_ACKE > 7) begin : g_ctrl_fields
        $error("control fields must sit in the low byte");
    end
    if (`IWC_IRQ_WAIT == `IWC_IRQ_STOP || `IWC_IRQ_WAIT > 1 ||
        `IWC_IRQ_STOP > 1) begin : g_irq_fields
        $error("interrupt bits must be distinct and in the low two bits");
    end
    // The reset state clears every control bit.
    if (`IWC_CTRL_RESET != 8'h00) begin : g_ctrl_reset
        $error("control reset value must be zero");
    end

    // Chooses where in the byte the wait and interrupt fall.
    function automatic iwc_wait_pt_t wait_point(
        input logic addr_phase,
        input iwc_role_t rl,
        input logic wtim
    );
        iwc_wait_pt_t pt;
        if (addr_phase) begin
            if (rl.master_mode) begin
                pt = IWC_WAIT_AT_9;
            end else if (rl.extension_code_flag) begin
                pt = IWC_WAIT_AT_8;
            end else if (rl.base_addr_match) begin
                pt = IWC_WAIT_AT_9;
            end else begin
                pt = IWC_WAIT_NONE;
            end
        end else begin
            pt = wtim ? IWC_WAIT_AT_9 : IWC_WAIT_AT_8;
        end
        return pt;
    endfunction

    // Decides whether this end pulls the data line low in the ninth clock.
    function automatic logic ack_wanted(
        input logic addr_phase,
        input iwc_role_t rl,
        input logic acke
    );
        logic a;
        if (addr_phase) begin
            if (rl.master_mode) begin
                a = 1'b0;
            end else if (rl.extension_code_flag) begin
                a = acke;
            end else begin
                a = rl.base_addr_match;
            end
        end else begin
            a = acke && !rl.transmitting;
        end
        return a;
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [7:0] addr,
        input iwc_state_t s
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (addr)
            `IWC_OFF_CTRL: begin
                d[`IWC_CTRL_ENABLE] = s.ctrl.bus_unit_enable;
                d[`IWC_CTRL_WREL] = s.ctrl.wait_release;
                d[`IWC_CTRL_SPIE] = s.ctrl.stop_irq_enable;
                d[`IWC_CTRL_WTIM] = s.ctrl.wait_timing_select;
                d[`IWC_CTRL_ACKE] = s.ctrl.ack_enable;
            end
            `IWC_OFF_STATUS: begin
                d[9:0] = {s.bit_cnt, s.in_frame, s.addr_phase, s.waiting,
                    s.scl_f, s.sda_f, s.sda_drv};
            end
            `IWC_OFF_IRQ_STAT: begin
                d[1:0] = s.irq_stat;
            end
            `IWC_OFF_IRQ_MASK: begin
                d[1:0] = s.irq_mask;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        return addr == `IWC_OFF_CTRL || addr == `IWC_OFF_STATUS ||
            addr == `IWC_OFF_IRQ_STAT || addr == `IWC_OFF_IRQ_MASK;
    endfunction

    // Follows a pin once synchroniser stages two and three agree.
    function automatic logic settled(
        input logic [2:0] stages,
        input logic held
    );
        logic lvl;
        lvl = held;
        if (stages[1] == stages[2]) begin
            lvl = stages[2];
        end
        return lvl;
    endfunction

    // APB phase decode, shared by the register logic and the error output.
    function automatic logic in_access(input iwc_apb_req_t rq);
        return rq.psel && rq.penable;
    endfunction

    function automatic logic in_setup(input iwc_apb_req_t rq);
        return rq.psel && !rq.penable;
    endfunction

    // Unpacks a control register write.
    function automatic iwc_ctrl_t ctrl_from_word(input logic [31:0] w);
        iwc_ctrl_t c;
        c.bus_unit_enable = w[`IWC_CTRL_ENABLE];
        c.wait_release = w[`IWC_CTRL_WREL];
        c.stop_irq_enable = w[`IWC_CTRL_SPIE];
        c.wait_timing_select = w[`IWC_CTRL_WTIM];
        c.ack_enable = w[`IWC_CTRL_ACKE];
        return c;
    endfunction

    // A new event wins over a read clear in the same cycle.
    function automatic logic [1:0] sticky(
        input logic [1:0] old,
        input logic [1:0] clr,
        input logic [1:0] ev
    );
        return (old & ~clr) | ev;
    endfunction

    always_comb begin
        logic scl_fall;
        logic start_det;
        logic stop_det;
        logic en;
        logic setup;
        logic access;
        logic wait_ev;
        logic stop_ev;
        logic [1:0] read_clr;
        iwc_wait_pt_t pt;
        logic [1:0] ev;

        n = r;
        pt = IWC_WAIT_NONE;
        ev = 2'h0;
        scl_fall = 1'b0;
        start_det = 1'b0;
        stop_det = 1'b0;
        wait_ev = 1'b0;
        stop_ev = 1'b0;
        read_clr = 2'h0;
        en = r.ctrl.bus_unit_enable;
        setup = in_setup(apb_req);
        access = in_access(apb_req);

        // Three-stage synchronisers; a level counts once stages two and
        // three agree.
        n.scl_s = {r.scl_s[1:0], serial_clock_line_in};
        n.sda_s = {r.sda_s[1:0], serial_data_line_in};
        n.scl_f = settled(r.scl_s, r.scl_f);
        n.sda_f = settled(r.sda_s, r.sda_f);
        scl_fall = r.scl_f && !n.scl_f;
        start_det = r.scl_f && n.scl_f && r.sda_f && !n.sda_f;
        stop_det = r.scl_f && n.scl_f && !r.sda_f && n.sda_f;

        // The release bit lives for one cycle and frees any wait.
        n.ctrl.wait_release = 1'b0;
        if (r.ctrl.wait_release) begin
            n.waiting = 1'b0;
        end

        pt = wait_point(r.addr_phase, role, r.ctrl.wait_timing_select);
        if (!en) begin
            n.bit_cnt = 4'h0;
            n.in_frame = 1'b0;
            n.addr_phase = 1'b0;
            n.waiting = 1'b0;
        end else if (start_det) begin
            n.in_frame = 1'b1;
            n.addr_phase = 1'b1;
            // The clock fall that closes the start is no data bit; the
            // marker wraps to zero on it.
            n.bit_cnt = `IWC_CNT_START;
        end else if (stop_det) begin
            n.in_frame = 1'b0;
            n.addr_phase = 1'b0;
            n.bit_cnt = 4'h0;
            stop_ev = r.ctrl.stop_irq_enable;
        end else if (scl_fall && r.in_frame) begin
            if (r.bit_cnt == `IWC_CNT_8TH) begin
                n.bit_cnt = r.bit_cnt + 4'h1;
                wait_ev = (pt == IWC_WAIT_AT_8);
            end else if (r.bit_cnt == `IWC_CNT_9TH) begin
                n.bit_cnt = 4'h0;
                n.addr_phase = 1'b0;
                wait_ev = (pt == IWC_WAIT_AT_9);
            end else begin
                n.bit_cnt = r.bit_cnt + 4'h1;
            end
        end
        // A wait event in the release cycle arms the next wait again.
        if (wait_ev) begin
            n.waiting = 1'b1;
        end

        // Acknowledge is driven for the whole ninth clock period.
        n.sda_drv = en && n.in_frame && n.bit_cnt == `IWC_CNT_9TH &&
            ack_wanted(n.addr_phase, role, r.ctrl.ack_enable);

        // APB: read data and error are latched in the setup cycle.
        // A read clear uses this copy, so a later event is never lost.
        if (setup) begin
            n.prdata = apb_req.pwrite ? 32'h0000_0000 :
                read_mux(apb_req.paddr, r);
            n.pslverr = !mapped(apb_req.paddr);
        end
        if (access && !apb_req.pwrite &&
            apb_req.paddr == `IWC_OFF_IRQ_STAT) begin
            read_clr = r.prdata[1:0];
        end
        if (access && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                `IWC_OFF_CTRL: begin
                    n.ctrl = ctrl_from_word(apb_req.pwdata);
                end
                `IWC_OFF_IRQ_MASK: begin
                    n.irq_mask = apb_req.pwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky events.
        ev[`IWC_IRQ_WAIT] = wait_ev;
        ev[`IWC_IRQ_STOP] = stop_ev;
        n.irq_stat = sticky(r.irq_stat, read_clr, ev);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RESET_STATE;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = r.pslverr && in_access(apb_req);
    // Open-drain pins: they only ever pull low, through the enables.
    assign serial_clock_line_out = 1'b0;
    assign serial_clock_line_oe = r.waiting;
    assign serial_data_line_out = 1'b0;
    assign serial_data_line_oe = r.sda_drv;
    assign wait_active = r.waiting;
    assign transfer_interrupt = |(r.irq_stat & r.irq_mask);

endmodule

// ===== bench/iwc_ctrl_checker.sv
// Port assertions for the bus wait control block.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module iwc_ctrl_checker
    import iwc_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB.
    input wire iwc_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus pins.
    input wire logic serial_clock_line_in,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    // Role and status.
    input wire iwc_role_t role,
    input wire logic wait_active,
    input wire logic transfer_interrupt
);
    logic wr_c;
    logic rd_s;
    logic en_q;
    assign wr_c = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == `IWC_OFF_CTRL;
    assign rd_s = apb_req.psel && apb_req.penable && !apb_req.pwrite
        && apb_req.paddr == `IWC_OFF_IRQ_STAT;
    // Shadow of the unit enable, taken from control writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
        end else if (wr_c) begin
            en_q <= apb_req.pwdata[`IWC_CTRL_ENABLE];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_WAIT_PIN: assert property (wait_active |-> serial_clock_line_oe)
        else $error("wait without clock hold");
    AST_WAIT_HOLD: assert property (wait_active && !wr_c && !$past(wr_c)
        && !$past(wr_c, 2) |=> wait_active) else $error("wait lost");
    AST_RELEASE: assert property (wr_c && wait_active
        && apb_req.pwdata[`IWC_CTRL_WREL] && apb_req.pwdata[`IWC_CTRL_ENABLE]
        |-> ##[1:3] !wait_active) else $error("wait not released");
    AST_WAIT_LOW: assert property ($rose(wait_active)
        |-> !serial_clock_line_in) else $error("wait with clock high");
    AST_DISABLED: assert property (!en_q && !$past(en_q)
        |-> !serial_clock_line_oe && !serial_data_line_oe)
        else $error("pin driven while disabled");
    AST_ACK_RISE: assert property ($rose(serial_data_line_oe)
        |-> !$past(serial_clock_line_in)) else $error("ack began high");
    AST_ACK_HOLD: assert property ($fell(serial_data_line_oe)
        |-> !serial_clock_line_in && !$past(serial_clock_line_in, 3))
        else $error("ack ended early");
    AST_IRQ_CLR: assert property (rd_s |=> !transfer_interrupt)
        else $error("interrupt kept after read");
    AST_OPEN_DRAIN: assert property (!serial_clock_line_out
        && !serial_data_line_out) else $error("pin driven high");
    cover property ($rose(wait_active));
    cover property ($rose(serial_data_line_oe));
    cover property ($rose(transfer_interrupt));
endmodule

// ===== bench/iwc_bus_model.sv
// Two-wire bus master model that frames bytes and honours stretching.
`timescale 1ns/100ps
module iwc_bus_model (
    // Wired bus levels.
    input wire logic scl_w,
    input wire logic sda_w,
    // Pull-down requests of this party.
    output logic scl_low,
    output logic sda_low
);
    logic ack_seen;
    int hangs;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        ack_seen = 1'b0;
        hangs = 0;
    end
    task automatic frame_start();
        sda_low = 1'b1;
        #24 scl_low = 1'b1;
        #24 sda_low = 1'b0;
    endtask
    task automatic frame_stop();
        sda_low = 1'b1;
        #24 scl_low = 1'b0;
        #24 sda_low = 1'b0;
        #24;
    endtask
    // One clock pulse; the high phase waits until nobody holds the line.
    task automatic pulse();
        int n;
        n = 0;
        #24 scl_low = 1'b0;
        while (!scl_w && n < 4000) begin
            #1 n++;
        end
        if (!scl_w)
            hangs++;
        #12 ack_seen = !sda_w;
        #12 scl_low = 1'b1;
    endtask
endmodule

// ===== bench/iwc_ctrl_bench.sv
// Self-checking bench for the bus wait control block.
`timescale 1ns/100ps
`include "iwc_consts.svh"
module iwc_ctrl_bench
    import iwc_pkg::*;
;
    logic pclk;
    logic presetn;
    iwc_apb_req_t req;
    iwc_role_t role;
    logic [31:0] prdata;
    logic [31:0] rd_v;
    logic pready, pslverr, rd_e, wait_active, irq;
    logic scl_out, scl_oe, sda_out, sda_oe, scl_w, sda_w, m_scl, m_sda;
    int miscompares;
    int checked;
    assign scl_w = !(scl_oe || m_scl);
    assign sda_w = !(sda_oe || m_sda);
    iwc_ctrl iwc_ctrl_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_line_in(scl_w), .serial_clock_line_out(scl_out),
        .serial_clock_line_oe(scl_oe), .serial_data_line_in(sda_w),
        .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
        .role(role), .wait_active(wait_active), .transfer_interrupt(irq));
    iwc_bus_model iwc_bus_model_inst (.scl_w(scl_w), .sda_w(sda_w),
        .scl_low(m_scl), .sda_low(m_sda));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_v = prdata;
        rd_e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic irq_chk(input logic [1:0] e);
        chk(32'(irq), 32'h1);
        apb(1'b0, `IWC_OFF_IRQ_STAT, 32'h0);
        chk(rd_v, 32'(e));
        @(posedge pclk);
        chk(32'(irq), 32'h0);
    endtask
    task automatic byte_run(input logic st, input logic [3:0] rl,
        input logic [7:0] c, input int wp, input logic ack);
        role <= iwc_role_t'(rl);
        apb(1'b1, `IWC_OFF_CTRL, {24'h0, c});
        if (st)
            iwc_bus_model_inst.frame_start();
        repeat (8) iwc_bus_model_inst.pulse();
        repeat (12) @(posedge pclk);
        chk(32'(wait_active), 32'(wp == 8));
        if (wp == 8) begin
            irq_chk(2'h1);
            fork
                iwc_bus_model_inst.pulse();
                begin
                    repeat (20) @(posedge pclk);
                    chk(32'(scl_w), 32'h0);
                    apb(1'b1, `IWC_OFF_CTRL, {24'h0, c | 8'h40});
                end
            join
        end else
            iwc_bus_model_inst.pulse();
        chk(32'(iwc_bus_model_inst.ack_seen), 32'(ack));
        repeat (12) @(posedge pclk);
        chk(32'(wait_active), 32'(wp == 9));
        if (wp == 9) begin
            irq_chk(2'h1);
            apb(1'b1, `IWC_OFF_CTRL, {24'h0, c | 8'h40});
        end
        repeat (4) @(posedge pclk);
        chk(32'(sda_oe), 32'h0);
    endtask
    task automatic stop_run(input logic [7:0] c, input logic [1:0] e);
        apb(1'b1, `IWC_OFF_CTRL, {24'h0, c});
        iwc_bus_model_inst.frame_stop();
        repeat (12) @(posedge pclk);
        chk(32'(irq), 32'(e != 2'h0));
        apb(1'b0, `IWC_OFF_IRQ_STAT, 32'h0);
        chk(rd_v, 32'(e));
    endtask
    initial begin
        presetn = 1'b0;
        req = '0;
        role = '0;
        miscompares = 0;
        checked = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IWC_OFF_CTRL, 32'h0);
        chk(rd_v, 32'(`IWC_CTRL_RESET));
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(rd_e), 32'h1);
        apb(1'b1, `IWC_OFF_IRQ_MASK, 32'h3);
        byte_run(1'b1, 4'b1100, 8'h80, 9, 1'b0);
        byte_run(1'b0, 4'b1100, 8'h84, 8, 1'b0);
        byte_run(1'b0, 4'b1000, 8'h8C, 9, 1'b1);
        byte_run(1'b0, 4'b1000, 8'h80, 8, 1'b0);
        apb(1'b0, `IWC_OFF_CTRL, 32'h0);
        chk(rd_v, 32'h80);
        stop_run(8'h90, 2'h2);
        byte_run(1'b1, 4'b0001, 8'h8C, 8, 1'b1);
        stop_run(8'h80, 2'h0);
        byte_run(1'b1, 4'b0010, 8'h80, 9, 1'b1);
        stop_run(8'h80, 2'h0);
        byte_run(1'b1, 4'b0000, 8'h84, 0, 1'b0);
        stop_run(8'h80, 2'h0);
        byte_run(1'b1, 4'b1000, 8'h5C, 0, 1'b0);
        apb(1'b0, `IWC_OFF_STATUS, 32'h0);
        chk(rd_v, 32'h2);
        chk(32'(iwc_bus_model_inst.hangs), 32'h0);
        conclude();
    end
endmodule
bind iwc_ctrl iwc_ctrl_checker iwc_ctrl_checker_inst (.*);
